// ---- design/ctm_top.sv ----
/*
  Compact timer: 16-bit up-counter with comparators A and P, three operating
  modes (compare-match output, timer/counter, PWM), two sticky match flags
  and one output pin, reached over a plain 8-bit register port.
  Assumes one 40 MHz clock, inputs synchronous to it, and eight counter
  tick enables supplied by the surrounding clock logic.
*/
// The placing of the registers and the address-and-strobe port are this design's own decisions.
//Contract
//RULE1 - Mode field 00 selects compare-match output operation.
//RULE2 - Mode field 11 acts as compare-match but leaves the pin unused.
//RULE3 - Mode field 10 produces a fixed-frequency, variable-duty PWM waveform.
//RULE4 - Clear-select low: clear on P match, or overflow when P is zero; both flags.
//RULE5 - Clear-select high: clear on A match; only the A flag is raised.
//RULE6 - Clear-select high with A zero: overflow at FFFF, no A flag.
//RULE7 - In compare-match output the pin changes only on an A match.
//RULE8 - A match drives the pin high, low or toggles; zero means no change.
//RULE9 - Pin action codes: 00 none, 01 low, 10 high, 11 toggle.
//RULE10 - Counter-on rising edge loads the pin with its initial level.
//RULE11 - PWM ignores clear-select; swap bit chooses period and duty registers.
//RULE12 - PWM raises the A flag on A matches and P flag on P matches.
//RULE13 - PWM: initial bit sets active level, action forces or enables, invert.
//RULE14 - Swap 0: period is P times 256 or 65536; duty is A.
//RULE15 - Duty at or above period holds the output active all period.
//RULE16 - Swap 1: period is A; duty is P times 256 or 65536.
//RULE17 - PWM counting and flags continue while the output is forced.
//RULE18 - P compares against the upper count byte only, in 256-clock steps.
//RULE19 - Counter-on rising edge zeroes the counter; falling edge keeps it.
//RULE20 - While on and not paused, the counter increments on each tick.
`timescale 1ns/1ps
`include "ctm_params.svh"

module ctm_top #(
  parameter int CNT_W  = 16,
  parameter int ADDR_W = 3
) (
  // Clock, reset and clock enable
  input  wire logic              CLK_SYS_I,
  input  wire logic              RST_N_I,
  input  wire logic              CE_I,
  // Register port
  input  wire logic [ADDR_W-1:0] REG_ADDR_I,
  input  wire logic [7:0]        REG_WDATA_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  output logic [7:0]             REG_RDATA_O,
  // Counter clock sources, one tick enable per selector code
  input  wire logic [7:0]        CNT_TICKS_I,
  // Output pin and status
  output logic                   TIMER_PIN_O,
  output logic                   TIMER_PIN_OE_O,
  output logic                   MATCH_A_FLAG_O,
  output logic                   MATCH_P_FLAG_O
);

  // ============================================================
  // Elaboration checks

  // The comparator widths are fixed by the P byte and the 16-bit A value.
  if (CNT_W != 16) begin : g_bad_width
    $error("ctm_top: CNT_W must be 16");
  end
  if (ADDR_W < 3) begin : g_bad_addr
    $error("ctm_top: ADDR_W must be at least 3");
  end

  // ============================================================
  // Registers

  ctm_pkg::ctm_ctrl0_s ctrl0;
  ctm_pkg::ctm_ctrl1_s ctrl1;
  logic [15:0]         cmp_a;
  logic [7:0]          cmp_p;
  logic [15:0]         count;
  logic                pin_level;
  ctm_pkg::ctm_cmp_s   cmp;

  // ============================================================
  // Decoding

  wire logic [1:0] mode       = {ctrl1.mode_select_hi, ctrl1.mode_select_lo};
  wire logic [1:0] pin_action = {ctrl1.pin_action_hi, ctrl1.pin_action_lo};
  wire logic       is_pwm     = (mode == `CTM_MODE_PWM);                     // RULE3
  wire logic       is_cmp_out = (mode == `CTM_MODE_CMP);                     // RULE1
  // Mode 01 has no function here; it is served like the timer mode.
  wire logic       pin_used   = is_pwm || is_cmp_out;                        // RULE2

  // An access hits a register only when every address bit above the three
  // decoded ones is zero, so a wider port never aliases the map.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [2:0]        offset);
    reg_hit = ((addr >> 3) == '0) && (addr[2:0] == offset);
  endfunction

  wire logic       sel_ctrl0  = reg_hit(REG_ADDR_I, `CTM_OFF_CTRL0);
  wire logic       sel_ctrl1  = reg_hit(REG_ADDR_I, `CTM_OFF_CTRL1);
  wire logic       sel_a_lo   = reg_hit(REG_ADDR_I, `CTM_OFF_CMPA_LO);
  wire logic       sel_a_hi   = reg_hit(REG_ADDR_I, `CTM_OFF_CMPA_HI);
  wire logic       sel_p      = reg_hit(REG_ADDR_I, `CTM_OFF_CMPP);
  wire logic       sel_stat   = reg_hit(REG_ADDR_I, `CTM_OFF_STATUS);
  wire logic       addr_hi_ok = (REG_ADDR_I >> 3) == '0;

  wire logic       wr_ctrl0   = REG_WR_I && addr_hi_ok && sel_ctrl0;
  wire logic       wr_ctrl1   = REG_WR_I && addr_hi_ok && sel_ctrl1;
  wire logic       wr_a_lo    = REG_WR_I && addr_hi_ok && sel_a_lo;
  wire logic       wr_a_hi    = REG_WR_I && addr_hi_ok && sel_a_hi;
  wire logic       wr_p       = REG_WR_I && addr_hi_ok && sel_p;
  wire logic       wr_stat    = REG_WR_I && addr_hi_ok && sel_stat;

  // ============================================================
  // Counter control

  ctm_pkg::ctm_ctrl0_s wdata0;
  assign wdata0 = ctm_pkg::ctm_ctrl0_s'({REG_WDATA_I[7:3], 3'h0});

  wire logic on_rise = wr_ctrl0 && wdata0.counter_on && !ctrl0.counter_on;  // RULE19
  wire logic tick_src = CNT_TICKS_I[ctrl0.clk_sel];
  wire logic tick     = ctrl0.counter_on && !ctrl0.pause && tick_src;     // RULE20

  ctm_cmp u_cmp (
    .count_i     (count),
    .cmp_a_i     (cmp_a),
    .cmp_p_i     (cmp_p),
    .pwm_i       (is_pwm),
    .swap_i      (ctrl1.period_duty_swap),
    .clear_sel_i (ctrl1.clear_source_select),
    .res_o       (cmp)
  );

  // Flag events. Outside PWM the clear-select bit gates the P flag; an
  // overflow with P zero counts as the P match that clears the counter.
  wire logic p_ovf     = (cmp_p == 8'h00) && (count == 16'hffff);
  wire logic ev_a      = tick && cmp.hit_a;                                  // RULE12
  wire logic ev_p_cmp  = tick && !ctrl1.clear_source_select
                         && (cmp.hit_p || p_ovf);                           // RULE4 RULE5
  wire logic ev_p_pwm  = tick && cmp.hit_p;                                  // RULE12
  wire logic ev_p      = is_pwm ? ev_p_pwm : ev_p_cmp;                       // RULE17

  // Raising counter_on wins over a tick in the same cycle, so a restart
  // always begins from zero.
  wire logic [15:0] next_count = on_rise ? 16'h0000 :                       // RULE19
                                 tick    ? cmp.next_count : count;           // RULE4 RULE5 RULE6

  // ============================================================
  // Compare-match pin action

  logic next_pin_cmp;
  always_comb begin
    next_pin_cmp = pin_level;
    if (ev_a) begin                                                          // RULE7
      case (pin_action)                                                      // RULE8
        `CTM_ACT_NONE:   next_pin_cmp = pin_level;                           // RULE9
        `CTM_ACT_LOW:    next_pin_cmp = 1'b0;                                // RULE9
        `CTM_ACT_HIGH:   next_pin_cmp = 1'b1;                                // RULE9
        `CTM_ACT_TOGGLE: next_pin_cmp = !pin_level;                          // RULE9
        default:         next_pin_cmp = pin_level;
      endcase
    end
  end

  wire logic next_pin_level = on_rise ? wdata0.counter_on &&
                              ctrl1.output_initial_level : next_pin_cmp;      // RULE10

  // ============================================================
  // PWM waveform

  // The waveform follows the registered count, so the pin trails the
  // count by one clock; the trade keeps every output on a flip-flop.
  // Action 11 has no PWM use and parks the pin at its inactive level.
  logic pwm_active;
  always_comb begin
    case (pin_action)                                                        // RULE13
      `CTM_PWM_INACT: pwm_active = 1'b0;                                     // RULE17
      `CTM_PWM_ACT:   pwm_active = 1'b1;                                     // RULE17
      `CTM_PWM_RUN:   pwm_active = cmp.duty_active || cmp.full_duty;         // RULE15
      default:        pwm_active = 1'b0;
    endcase
  end

  wire logic pwm_level = pwm_active ? ctrl1.output_initial_level
                                    : !ctrl1.output_initial_level;           // RULE13
  wire logic raw_pin   = is_pwm ? pwm_level : pin_level;
  wire logic next_pin  = pin_used ? (raw_pin ^ ctrl1.output_invert) : 1'b0; // RULE13 RULE2

  // ============================================================
  // Sticky flags: a set in the clearing cycle wins.

  wire logic next_flag_a = ev_a ||
                           (MATCH_A_FLAG_O && !(wr_stat && REG_WDATA_I[`CTM_ST_MATCH_A]));
  wire logic next_flag_p = ev_p ||
                           (MATCH_P_FLAG_O && !(wr_stat && REG_WDATA_I[`CTM_ST_MATCH_P]));

  // ============================================================
  // Read data

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (REG_RD_I && addr_hi_ok) begin
      case (REG_ADDR_I[2:0])
        `CTM_OFF_CTRL0:   next_rdata = {ctrl0[7:3], 3'h0};
        `CTM_OFF_CTRL1:   next_rdata = ctrl1;
        `CTM_OFF_CNT_LO:  next_rdata = count[7:0];
        `CTM_OFF_CNT_HI:  next_rdata = count[15:8];
        `CTM_OFF_CMPA_LO: next_rdata = cmp_a[7:0];
        `CTM_OFF_CMPA_HI: next_rdata = cmp_a[15:8];
        `CTM_OFF_CMPP:    next_rdata = cmp_p;
        `CTM_OFF_STATUS:  next_rdata = {6'h00, MATCH_P_FLAG_O, MATCH_A_FLAG_O};
        default:          next_rdata = 8'h00;
      endcase
    end
  end

  // ============================================================
  // Configuration registers

  // Mode, pin action and compare values should only change while the
  // counter is off; a change in flight applies from the next tick as is.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      ctrl0 <= ctm_pkg::ctm_ctrl0_s'(`CTM_RST_BYTE);
    end else if (CE_I && wr_ctrl0) begin
      ctrl0 <= wdata0;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      ctrl1 <= ctm_pkg::ctm_ctrl1_s'(`CTM_RST_BYTE);
    end else if (CE_I && wr_ctrl1) begin
      ctrl1 <= ctm_pkg::ctm_ctrl1_s'(REG_WDATA_I);
    end
  end

  // The two A bytes are live as soon as each is written, so a running
  // counter can briefly compare against a half-updated value.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      cmp_a <= `CTM_RST_CMPA;
    end else if (CE_I) begin
      if (wr_a_lo)  cmp_a[7:0] <= REG_WDATA_I;
      if (wr_a_hi)  cmp_a[15:8] <= REG_WDATA_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      cmp_p <= `CTM_RST_BYTE;
    end else if (CE_I && wr_p) begin
      cmp_p <= REG_WDATA_I;
    end
  end

  // ============================================================
  // Counter

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      count <= 16'h0000;
    end else if (CE_I) begin
      count <= next_count;
    end
  end

  // ============================================================
  // Output pin

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      pin_level <= 1'b0;
    end else if (CE_I) begin
      pin_level <= next_pin_level;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      TIMER_PIN_O    <= 1'b0;
      TIMER_PIN_OE_O <= 1'b0;
    end else if (CE_I) begin
      TIMER_PIN_O    <= next_pin;
      TIMER_PIN_OE_O <= pin_used;                                            // RULE2
    end
  end

  // ============================================================
  // Match flags

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      MATCH_A_FLAG_O <= 1'b0;
      MATCH_P_FLAG_O <= 1'b0;
    end else if (CE_I) begin
      MATCH_A_FLAG_O <= next_flag_a;
      MATCH_P_FLAG_O <= next_flag_p;
    end
  end

  // ============================================================
  // Read data register

  // A read slot shows its byte for one cycle, then the port falls back to
  // zero so a stale value is never taken for a fresh one.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (CE_I) begin
      REG_RDATA_O <= next_rdata;
    end
  end

endmodule

// ---- pkg/ctm_params.svh ----
/*
  Register offsets, field positions, reset values and mode codes of the
  compact timer. Assumes an 8-bit register port with byte-sized offsets.
*/
`ifndef CTM_PARAMS_SVH
`define CTM_PARAMS_SVH

// ============================================================
// Register offsets
`define CTM_OFF_CTRL0    3'h0
`define CTM_OFF_CTRL1    3'h1
`define CTM_OFF_CNT_LO   3'h2
`define CTM_OFF_CNT_HI   3'h3
`define CTM_OFF_CMPA_LO  3'h4
`define CTM_OFF_CMPA_HI  3'h5
`define CTM_OFF_CMPP     3'h6
`define CTM_OFF_STATUS   3'h7

// ============================================================
// Field positions
`define CTM_C0_PAUSE     7
`define CTM_C0_ON        3
`define CTM_ST_MATCH_A   0
`define CTM_ST_MATCH_P   1

// ============================================================
// Mode and pin action codes
`define CTM_MODE_CMP     2'h0
`define CTM_MODE_PWM     2'h2
`define CTM_MODE_TMR     2'h3
`define CTM_ACT_NONE     2'h0
`define CTM_ACT_LOW      2'h1
`define CTM_ACT_HIGH     2'h2
`define CTM_ACT_TOGGLE   2'h3
`define CTM_PWM_INACT    2'h0
`define CTM_PWM_ACT      2'h1
`define CTM_PWM_RUN      2'h2

// ============================================================
// Reset values and timing
`define CTM_RST_BYTE     8'h00
`define CTM_RST_CMPA     16'h0000
`define CTM_P_STEP       256
`define CTM_FULL_SPAN    17'h10000

`endif

// ---- pkg/ctm_pkg.sv ----
/*
  Types of the compact timer: the two control register layouts and the comparator results.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ctm_pkg;

  // ============================================================
  // Control register 0
  typedef struct packed {
    logic       pause;
    logic [2:0] clk_sel;
    logic       counter_on;
    logic [2:0] unused;
  } ctm_ctrl0_s;

  // ============================================================
  // Control register 1 (timer_control_second)
  typedef struct packed {
    logic       mode_select_hi;
    logic       mode_select_lo;
    logic       pin_action_hi;
    logic       pin_action_lo;
    logic       output_initial_level;
    logic       output_invert;
    logic       period_duty_swap;
    logic       clear_source_select;
  } ctm_ctrl1_s;

  // ============================================================
  // Comparator results handed to the timer core
  typedef struct packed {
    logic        hit_a;
    logic        hit_p;
    logic        wrap;
    logic        full_duty;
    logic        duty_active;
    logic [15:0] next_count;
  } ctm_cmp_s;

endpackage

// ---- design/ctm_cmp.sv ----
/*
  Comparator unit of the compact timer: compares the incremented count
  with the A and P values and works out the period and duty spans.
  Assumes the caller applies the match and next-count results only on an enabled counter tick.
*/
`timescale 1ns/1ps
`include "ctm_params.svh"

module ctm_cmp (
  // Counter and compare values
  input  wire logic [15:0]      count_i,
  input  wire logic [15:0]      cmp_a_i,
  input  wire logic [7:0]       cmp_p_i,
  // Configuration
  input  wire logic             pwm_i,
  input  wire logic             swap_i,
  input  wire logic             clear_sel_i,
  // Results
  output ctm_pkg::ctm_cmp_s     res_o
);

  // ============================================================
  // Span helpers

  // A zero compare value stands for the full 65536-clock span.
  function automatic logic [16:0] span_a(input logic [15:0] a);
    span_a = (a == 16'h0000) ? `CTM_FULL_SPAN : {1'b0, a};
  endfunction

  // The P value counts in steps of 256 clocks against the upper byte.
  function automatic logic [16:0] span_p(input logic [7:0] p);
    span_p = (p == 8'h00) ? `CTM_FULL_SPAN : {1'b0, p, 8'h00};
  endfunction

  // ============================================================
  // Comparison

  wire logic [16:0] inc       = {1'b0, count_i} + 17'h00001;
  wire logic        hit_a     = (cmp_a_i != 16'h0000) && (inc[15:0] == cmp_a_i); // RULE6
  wire logic        hit_p     = (inc[15:8] == cmp_p_i) && (inc[7:0] == 8'h00)
                                && (cmp_p_i != 8'h00);                          // RULE18
  wire logic        use_a     = pwm_i ? swap_i : clear_sel_i;                   // RULE11
  wire logic [16:0] period    = use_a ? span_a(cmp_a_i) : span_p(cmp_p_i);      // RULE14 RULE16
  // An A duty of zero means zero here, unlike a zero period or a zero P duty.
  wire logic [16:0] duty      = swap_i ? span_p(cmp_p_i) : {1'b0, cmp_a_i};   // RULE14 RULE16
  wire logic        wrap      = (inc == period);
  wire logic        full_duty = (duty >= period);                             // RULE15
  wire logic        active    = full_duty || ({1'b0, count_i} < duty);

  assign res_o.hit_a       = hit_a;
  assign res_o.hit_p       = hit_p;
  assign res_o.wrap        = wrap;
  assign res_o.full_duty   = full_duty;
  assign res_o.duty_active = active;
  assign res_o.next_count  = wrap ? 16'h0000 : inc[15:0];

endmodule

// ---- tb/ctm_top_chk.sv ----
/* Port checker of the compact timer.
   Assumes it is bound to ctm_top; CE_I gates what the shadow takes. */
`timescale 1ns/1ps
module ctm_top_chk #(
  parameter int ADDR_W = 3
) (
  input wire logic              CLK_SYS_I,
  input wire logic              RST_N_I,
  input wire logic              CE_I,
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic [7:0]        REG_WDATA_I,
  input wire logic              REG_WR_I,
  input wire logic              REG_RD_I,
  input wire logic [7:0]        REG_RDATA_O,
  input wire logic              TIMER_PIN_O,
  input wire logic              TIMER_PIN_OE_O,
  input wire logic              MATCH_A_FLAG_O,
  input wire logic              MATCH_P_FLAG_O
);
  // ============================================================
  // Shadow of the configuration, rebuilt from observed writes
  logic [7:0]  c1;
  logic        on;
  logic [15:0] a;
  wire         wr   = REG_WR_I && CE_I;
  wire         w0   = wr && (REG_ADDR_I == ADDR_W'(0));
  wire         w1   = wr && (REG_ADDR_I == ADDR_W'(1));
  wire         w4   = wr && (REG_ADDR_I == ADDR_W'(4));
  wire         w5   = wr && (REG_ADDR_I == ADDR_W'(5));
  wire         cmpm = c1[7:6] != 2'h2;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      c1 <= 8'h00;
      on <= 1'b0;
      a  <= 16'h0000;
    end else begin
      if (w0) on <= REG_WDATA_I[3];
      if (w1) c1 <= REG_WDATA_I;
      if (w4) a[7:0] <= REG_WDATA_I;
      if (w5) a[15:8] <= REG_WDATA_I;
    end
  end
  // ============================================================
  // Assertions
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  a_rdata_idle: assert property (CE_I && !REG_RD_I |=> REG_RDATA_O == 8'h00)
    else $error("read data not zero outside read slot");
  a_tmr_pin_off: assert property (
    (c1[7:6] == 2'h3) [*3] |-> !TIMER_PIN_OE_O && !TIMER_PIN_O)
    else $error("pin used in timer mode");
  a_cmp_pin_en: assert property ((c1[7:6] == 2'h0) [*3] |-> TIMER_PIN_OE_O)
    else $error("pin not enabled in compare mode");
  a_pwm_pin_en: assert property ((c1[7:6] == 2'h2) [*3] |-> TIMER_PIN_OE_O)
    else $error("pin not enabled in pwm mode");
  a_p_flag_quiet: assert property (
    (cmpm && c1[0] && !MATCH_P_FLAG_O) ##1 (cmpm && c1[0]) |-> !MATCH_P_FLAG_O)
    else $error("p flag raised while clearing on a");
  a_a_zero_quiet: assert property (
    (a == 16'h0000 && !MATCH_A_FLAG_O) ##1 (a == 16'h0000) |-> !MATCH_A_FLAG_O)
    else $error("a flag raised with zero a value");
  a_pin_no_action: assert property (
    (c1[7:4] == 4'h0 && !REG_WR_I) [*3] |-> $stable(TIMER_PIN_O))
    else $error("pin moved with no-change action");
  a_on_initial: assert property (
    w0 && REG_WDATA_I[3] && !on && c1[7:6] == 2'h0 |-> ##2 TIMER_PIN_O == (c1[3] ^ c1[2]))
    else $error("pin not at initial level after start");
  a_pwm_forced: assert property (
    (on && c1[7:6] == 2'h2 && c1[5:4] != 2'h2) [*3]
    |-> TIMER_PIN_O == (c1[3] ^ c1[2] ^ (c1[5:4] != 2'h1)))
    else $error("forced pwm level wrong");
endmodule

bind ctm_top ctm_top_chk #(.ADDR_W(ADDR_W)) u_ctm_top_chk (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .TIMER_PIN_O(TIMER_PIN_O),
  .TIMER_PIN_OE_O(TIMER_PIN_OE_O), .MATCH_A_FLAG_O(MATCH_A_FLAG_O),
  .MATCH_P_FLAG_O(MATCH_P_FLAG_O));

// ---- tb/ctm_load_model.sv ----
/* Load on the timer pin: counts clocks at which the line is high.
   Assumes a pull-down on the line while the pin is not driven. */
`timescale 1ns/1ps
module ctm_load_model (
  input  wire logic clk_i,
  input  wire logic pin_i,
  input  wire logic oe_i,
  output int        high_total_o
);
  // A released line falls to the pull-down level, not the last value.
  wire level = oe_i ? pin_i : 1'b0;
  int  total = 0;
  assign high_total_o = total;
  always @(posedge clk_i) begin
    if (level) total <= total + 1;
  end
endmodule

// ---- tb/tb_ctm_top.sv ----
/* Self-checking bench of the compact timer.
   Assumes the bound checker and a load model on the pin. */
`timescale 1ns/1ps
module tb_ctm_top;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] ticks = 8'hff;
  logic [7:0] rdata, v;
  logic       pin, oe, fa, fp;
  int         mismatches = 0;
  int         n_tests = 0;
  int         hi_total, h0;
  logic [7:0]  pc1 [8] = '{8'ha8, 8'hac, 8'ha0, 8'ha8, 8'haa, 8'h98, 8'h88, 8'ha9};
  logic [15:0] pa [8] = '{16'h0040, 16'h0040, 16'h0040, 16'h0200, 16'h03e8,
                          16'h0040, 16'h0040, 16'h0040};
  int          pw [8] = '{256, 256, 256, 256, 1000, 256, 256, 256};
  int          pe [8] = '{64, 192, 192, 256, 256, 256, 0, 64};
  logic [7:0]  pst [8] = '{8'h03, 8'h03, 8'h03, 8'h02, 8'h03, 8'h03, 8'h03, 8'h03};

  initial begin
    forever #12.5 clk = ~clk;
  end

  ctm_top #(.ADDR_W(4)) u_ctm_top (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .CNT_TICKS_I(ticks), .TIMER_PIN_O(pin), .TIMER_PIN_OE_O(oe),
    .MATCH_A_FLAG_O(fa), .MATCH_P_FLAG_O(fp));
  ctm_load_model u_ctm_load_model (.clk_i(clk), .pin_i(pin), .oe_i(oe),
    .high_total_o(hi_total));

  // ============================================================
  // Bus and compare tasks
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task wrr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task rdr(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task rdchk(input string n, input logic [3:0] a, input logic [7:0] e);
    rdr(a, v);
    chk(n, e, v);
  endtask
  task setup(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p);
    wrr(4'h0, 8'h00);
    wrr(4'h1, c1);
    wrr(4'h4, a[7:0]);
    wrr(4'h5, a[15:8]);
    wrr(4'h6, p);
    wrr(4'h7, 8'h03);
    wrr(4'h0, 8'h08);
  endtask
  task cmp_case(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p,
                input int n, input logic epin, input logic eoe, input logic [7:0] est,
                input logic [7:0] ehi);
    setup(c1, a, p);
    repeat (n) @(posedge clk);
    wrr(4'h0, 8'h00);
    #1;
    chk("pin", epin, pin);
    chk("pin_enable", eoe, oe);
    chk("flag_a", est[0], fa);
    chk("flag_p", est[1], fp);
    rdchk("status", 4'h7, est);
    rdchk("count_hi", 4'h3, ehi);
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ============================================================
  // Test sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk("reset_value", 4'(i), 8'h00);
    wrr(4'h8, 8'hff);
    wrr(4'h2, 8'h55);
    rdchk("unmapped", 4'h8, 8'h00);
    rdchk("ctrl0", 4'h0, 8'h00);
    rdchk("count_lo", 4'h2, 8'h00);
    for (int k = 0; k < 4; k++)
      cmp_case({2'h0, 2'(k), k != 2, 3'h1}, 16'h0014, 8'h00, 25, !k[0], 1'b1,
               8'h01, 8'h00);
    cmp_case(8'hf1, 16'h0014, 8'h00, 25, 1'b0, 1'b0, 8'h01, 8'h00);
    cmp_case(8'h00, 16'h0080, 8'h01, 300, 1'b0, 1'b1, 8'h03, 8'h00);
    cmp_case(8'h01, 16'h0000, 8'h01, 300, 1'b0, 1'b1, 8'h00, 8'h01);
    wrr(4'h0, 8'h08);
    wrr(4'h0, 8'h88);
    rdr(4'h2, v);
    repeat (5) @(posedge clk);
    rdchk("paused", 4'h2, v);
    @(posedge clk) ticks <= 8'h00;
    wrr(4'h0, 8'h08);
    rdr(4'h2, v);
    repeat (5) @(posedge clk);
    rdchk("no_tick", 4'h2, v);
    @(posedge clk) ticks <= 8'hff;
    repeat (4) @(posedge clk);
    rdr(4'h2, v);
    @(posedge clk) ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    rdchk("ce_hold", 4'h2, v + 8'h03);
    wrr(4'h0, 8'h00);
    rdr(4'h2, v);
    repeat (5) @(posedge clk);
    rdchk("off_hold", 4'h2, v);
    wrr(4'h0, 8'h08);
    rdchk("on_zero", 4'h2, 8'h01);
    for (int k = 0; k < 8; k++) begin
      setup(pc1[k], pa[k], 8'h01);
      repeat (300) @(posedge clk);
      h0 = hi_total;
      repeat (pw[k]) @(posedge clk);
      chk("high_cycles", 16'(pe[k]), 16'(hi_total - h0));
      rdchk("pwm_status", 4'h7, pst[k]);
    end
    wrr(4'h0, 8'h00);
    wrr(4'h7, 8'h03);
    rdchk("flags_cleared", 4'h7, 8'h00);
    summarize;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize;
  end
endmodule
